// File: core/tbs_sequencer.sv
// traversing block sequencer: block table, selection, continuation logic
// assumes inputs synchronous to clock_i and a trajectory generator behind cmd_o
`timescale 1ns/100ps
`default_nettype none

module tbs_sequencer (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // controller inputs
  input wire logic [5:0] block_select_i,
  input wire logic activate_task_i,
  input wire logic continue_strobe_i,
  input wire logic external_change_i,
  input wire logic probe_change_i,
  input wire logic hold_request_n_i,
  input wire logic keep_task_n_i,
  input wire tbs_pkg::tbs_opmode_type op_mode_i,
  // trajectory generator
  input wire tbs_pkg::tbs_motion_type motion_i,
  output tbs_pkg::tbs_cmd_type cmd_o,
  output logic start_o,
  output logic hold_o,
  output logic cancel_o,
  output logic [15:0] brake_decel_o,
  // alarms
  output logic hidden_alarm_o,
  output logic missed_external_change_alarm_o,
  output logic fault_o
);
  import tbs_pkg::*;

  typedef struct packed {
    tbs_state_type fsm;
    logic [5:0] act_idx;
    logic [7:0] cur_num;
    logic [3:0] cont;
    logic [5:0] scan_idx;
    logic found;
    logic [7:0] best_num;
    logic [5:0] best_idx;
    logic [6:0] max_count;
    logic [2:0] cfg;
    logic [15:0] max_decel;
    logic [15:0] hold_decel;
    logic act_prev;
    logic cont_prev;
    logic ext_prev;
    logic probe_prev;
    logic hide_alm;
    logic miss_alm;
    logic fault;
    logic mode_alm;
    tbs_cmd_type cmd;
    logic start;
    logic hold;
    logic cancel;
    logic [15:0] brake_decel;
    logic [31:0] rdata;
  } tbs_regs_type;

  localparam tbs_regs_type REGS_RST = '{fsm: ST_IDLE, max_count: MAX_COUNT_RST,
    cfg: CONFIG_RST, max_decel: MAX_DECEL_RST, hold_decel: HOLD_DECEL_RST, default: '0};

  tbs_regs_type r_reg;
  tbs_regs_type r_next;
  tbs_entry_type table_mem [TBS_ENTRIES];

  // block needs a modulo axis it does not have
  function automatic logic bad_mode(input tbs_entry_type e, input logic modulo);
    logic [3:0] pm;
    pm = e.mode[POSM_LSB +: 4];
    bad_mode = (e.code == TASK_POSITIONING) && !modulo &&
      (pm == POSM_MODULO_POSITIVE_APPROACH || pm == POSM_MODULO_NEGATIVE_APPROACH);
  endfunction

  // table write decode
  logic tbl_wr;
  logic [5:0] wr_idx;
  logic [2:0] wr_fld;
  assign tbl_wr = wr_i && addr_i[ADDR_TABLE_BIT];
  assign wr_idx = addr_i[IDX_MSB:IDX_LSB];
  assign wr_fld = addr_i[FLD_MSB:0];

  // one table entry per loop pass, numbers start as skipped
  for (genvar g = 0; g < TBS_ENTRIES; g++) begin : g_entry
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        table_mem[g] <= '{num: NUM_SKIP, default: '0};
      end else if (tbl_wr && wr_idx == 6'(g)) begin
        unique case (wr_fld)
          FLD_NUM: table_mem[g].num <= wdata_i[7:0];
          FLD_CODE: table_mem[g].code <= wdata_i[3:0];
          FLD_TARGET: table_mem[g].target <= wdata_i;
          FLD_VEL: table_mem[g].vel <= wdata_i;
          FLD_ACC: table_mem[g].acc <= wdata_i[15:0];
          FLD_DEC: table_mem[g].dec <= wdata_i[15:0];
          FLD_MODE: table_mem[g].mode <= {4'h0, wdata_i[11:0]};
          FLD_ARG: table_mem[g].arg <= wdata_i;
        endcase
      end
    end
  end

  // edges, mode gate and selection checks
  logic act_edge;
  logic cont_edge;
  logic ext_edge;
  logic mode_ok;
  logic hold_req;
  logic cancel_req;
  tbs_entry_type sel_entry;
  tbs_entry_type scan_entry;
  tbs_entry_type rd_entry;
  logic sel_valid;
  logic sel_hidden;
  logic sel_bad;
  assign act_edge = activate_task_i && !r_reg.act_prev;
  assign cont_edge = continue_strobe_i && !r_reg.cont_prev;
  assign ext_edge = r_reg.cfg[CFG_SRC_BIT] ? (external_change_i && !r_reg.ext_prev)
    : (probe_change_i && !r_reg.probe_prev);
  assign mode_ok = (op_mode_i == OPM_BLOCKS) || (op_mode_i == OPM_DIRECT_SETPOINT);
  assign hold_req = mode_ok && !hold_request_n_i;
  assign cancel_req = mode_ok && !keep_task_n_i;
  assign sel_entry = table_mem[block_select_i];
  assign scan_entry = table_mem[r_reg.scan_idx];
  assign rd_entry = table_mem[addr_i[IDX_MSB:IDX_LSB]];
  assign sel_valid = ({1'b0, block_select_i} < r_reg.max_count) && sel_entry.num != NUM_SKIP;
  assign sel_hidden = sel_entry.mode[HIDE_LSB +: 4] == HIDE_ON;
  assign sel_bad = bad_mode(sel_entry, motion_i.modulo_axis);

  // next-state logic
  logic ld;
  logic [5:0] ld_idx;
  tbs_entry_type ld_entry;
  always_comb begin
    r_next = r_reg;
    ld = 1'b0;
    ld_idx = '0;
    ld_entry = '0;
    r_next.start = 1'b0;
    r_next.rdata = '0;
    r_next.act_prev = activate_task_i;
    r_next.cont_prev = continue_strobe_i;
    r_next.ext_prev = external_change_i;
    r_next.probe_prev = probe_change_i;
    if (r_reg.fsm != ST_SEARCH) begin
      r_next.scan_idx = '0;
      r_next.found = 1'b0;
    end
    // register writes; alarm clears come before sets so a set wins
    if (wr_i && !addr_i[ADDR_TABLE_BIT]) begin
      unique case (addr_i)
        REG_MAX_COUNT: r_next.max_count = wdata_i[6:0];
        REG_CONFIG: r_next.cfg = wdata_i[2:0];
        REG_MAX_DECEL: r_next.max_decel = wdata_i[15:0];
        REG_HOLD_DECEL: r_next.hold_decel = wdata_i[15:0];
        REG_STATUS: begin
          if (wdata_i[ST_HIDE_BIT]) r_next.hide_alm = 1'b0;
          if (wdata_i[ST_MISS_BIT]) r_next.miss_alm = 1'b0;
          if (wdata_i[ST_FAULT_BIT]) r_next.fault = 1'b0;
          if (wdata_i[ST_MODE_BIT]) r_next.mode_alm = 1'b0;
        end
        default: ;
      endcase
    end
    // continuation per code of the running block
    unique case (r_reg.fsm)
      ST_IDLE: ;
      ST_RUN: begin
        unique case (r_reg.cont)
          CONT_STOP: if (motion_i.standstill_in_window) r_next.fsm = ST_SEARCH;
          CONT_FLY: begin
            if (motion_i.brake_point && (!motion_i.direction_change || motion_i.standstill_in_window))
              r_next.fsm = ST_SEARCH;
          end
          CONT_EXT: begin
            if (ext_edge && !motion_i.brake_point) begin
              r_next.fsm = ST_SEARCH;
            end else if (motion_i.brake_point &&
                (!motion_i.direction_change || motion_i.standstill_in_window)) begin
              r_next.fsm = ST_SEARCH;
            end
          end
          CONT_WAIT, CONT_ALARM: begin
            if (ext_edge) begin
              r_next.fsm = ST_SEARCH;
            end else if (motion_i.standstill_in_window) begin
              r_next.fsm = ST_PARK;
              if (r_reg.cont == CONT_ALARM) begin
                r_next.miss_alm = 1'b1;
                if (r_reg.cfg[CFG_FAULT_BIT]) begin
                  r_next.fault = 1'b1;
                  r_next.fsm = ST_IDLE;
                end
              end
            end
          end
          default: if (motion_i.standstill_in_window) r_next.fsm = ST_PARK;
        endcase
      end
      ST_PARK: begin
        // wait and alarm codes resume on the external edge, every other code on continue
        if ((r_reg.cont == CONT_WAIT || r_reg.cont == CONT_ALARM) ? ext_edge : cont_edge)
          r_next.fsm = ST_SEARCH;
      end
      ST_SEARCH: begin
        // one entry a cycle: smallest number above the current one
        if ({1'b0, r_reg.scan_idx} < r_reg.max_count && scan_entry.num != NUM_SKIP &&
            scan_entry.num > r_reg.cur_num && (!r_reg.found || scan_entry.num < r_reg.best_num)) begin
          r_next.found = 1'b1;
          r_next.best_num = scan_entry.num;
          r_next.best_idx = r_reg.scan_idx;
        end
        r_next.scan_idx = r_reg.scan_idx + 6'h1;
        if (r_reg.scan_idx == 6'h3F) begin
          if (r_next.found) begin
            ld = 1'b1;
            ld_idx = r_next.best_idx;
          end else begin
            r_next.fsm = ST_IDLE;
          end
        end
      end
    endcase
    // explicit selection overrides the sequence
    if (act_edge && sel_valid) begin
      if (sel_hidden) begin
        r_next.hide_alm = 1'b1;
      end else begin
        ld = 1'b1;
        ld_idx = block_select_i;
      end
    end
    // block change: take over the whole entry
    if (ld && !cancel_req && !r_reg.fault) begin
      ld_entry = table_mem[ld_idx];
      if (bad_mode(ld_entry, motion_i.modulo_axis)) begin
        r_next.mode_alm = 1'b1;
        r_next.fsm = ST_IDLE;
      end else begin
        r_next.fsm = ST_RUN;
        r_next.start = 1'b1;
        r_next.act_idx = ld_idx;
        r_next.cur_num = ld_entry.num;
        r_next.cont = ld_entry.mode[CONT_LSB +: 4];
        r_next.cmd.task_code = ld_entry.code;
        r_next.cmd.vel = ld_entry.vel;
        r_next.cmd.acc = ld_entry.acc;
        r_next.cmd.dec = ld_entry.dec;
        r_next.cmd.arg = ld_entry.arg;
        r_next.cmd.target = ld_entry.target;
        r_next.cmd.dir_pos_only = 1'b0;
        r_next.cmd.dir_neg_only = 1'b0;
        if (ld_entry.code == TASK_POSITIONING) begin
          unique case (ld_entry.mode[POSM_LSB +: 4])
            POSM_RELATIVE: r_next.cmd.target = 32'(motion_i.actual_pos + ld_entry.target);
            POSM_MODULO_POSITIVE_APPROACH: r_next.cmd.dir_pos_only = 1'b1;
            POSM_MODULO_NEGATIVE_APPROACH: r_next.cmd.dir_neg_only = 1'b1;
            default: ;
          endcase
        end
      end
    end
    // cancel aborts everything, hold only brakes
    if (cancel_req) r_next.fsm = ST_IDLE;
    r_next.hold = hold_req;
    r_next.cancel = cancel_req;
    r_next.brake_decel = cancel_req ? r_reg.max_decel
      : (r_reg.cfg[CFG_HOLDSRC_BIT] ? r_reg.hold_decel : r_reg.cmd.dec);
    // register reads, answered in the next cycle
    if (rd_i) begin
      if (addr_i[ADDR_TABLE_BIT]) begin
        unique case (addr_i[FLD_MSB:0])
          FLD_NUM: r_next.rdata = {24'h00_0000, rd_entry.num};
          FLD_CODE: r_next.rdata = {28'h000_0000, rd_entry.code};
          FLD_TARGET: r_next.rdata = rd_entry.target;
          FLD_VEL: r_next.rdata = rd_entry.vel;
          FLD_ACC: r_next.rdata = {16'h0000, rd_entry.acc};
          FLD_DEC: r_next.rdata = {16'h0000, rd_entry.dec};
          FLD_MODE: r_next.rdata = {16'h0000, rd_entry.mode};
          FLD_ARG: r_next.rdata = rd_entry.arg;
        endcase
      end else begin
        unique case (addr_i)
          REG_MAX_COUNT: r_next.rdata = {25'h000_0000, r_reg.max_count};
          REG_CONFIG: r_next.rdata = {29'h0000_0000, r_reg.cfg};
          REG_MAX_DECEL: r_next.rdata = {16'h0000, r_reg.max_decel};
          REG_HOLD_DECEL: r_next.rdata = {16'h0000, r_reg.hold_decel};
          REG_STATUS: r_next.rdata = {18'h0_0000, r_reg.act_idx, r_reg.mode_alm,
            r_reg.fault, r_reg.miss_alm, r_reg.hide_alm, r_reg.fsm};
          default: r_next.rdata = '0;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) r_reg <= REGS_RST;
    else r_reg <= r_next;
  end

  // outputs from flops
  assign rdata_o = r_reg.rdata;
  assign cmd_o = r_reg.cmd;
  assign start_o = r_reg.start;
  assign hold_o = r_reg.hold;
  assign cancel_o = r_reg.cancel;
  assign brake_decel_o = r_reg.brake_decel;
  assign hidden_alarm_o = r_reg.hide_alm;
  assign missed_external_change_alarm_o = r_reg.miss_alm;
  assign fault_o = r_reg.fault;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic quiet;
  assign quiet = !act_edge && !cancel_req;

  a_select_starts: assert property (act_edge && sel_valid && !sel_hidden && !sel_bad && !cancel_req
    && !r_reg.fault |=> start_o && r_reg.act_idx == $past(block_select_i))
    else $error("valid selection did not start the block");
  a_hidden_refused: assert property (act_edge && sel_valid && sel_hidden |=> hidden_alarm_o
    && !(start_o && r_reg.act_idx == $past(block_select_i)))
    else $error("hidden block was started or not alarmed");
  a_end_waits_edge: assert property (r_reg.fsm == ST_PARK && r_reg.cont == CONT_END && !cont_edge
    && quiet |=> !start_o && r_reg.fsm == ST_PARK)
    else $error("end block advanced without continue edge");
  a_stop_needs_window: assert property (r_reg.fsm == ST_RUN && r_reg.cont == CONT_STOP
    && !motion_i.standstill_in_window && quiet |=> r_reg.fsm == ST_RUN)
    else $error("stop block left before standstill");
  a_fly_at_brake: assert property (r_reg.fsm == ST_RUN && r_reg.cont == CONT_FLY
    && motion_i.brake_point && !motion_i.direction_change && quiet |=> r_reg.fsm == ST_SEARCH)
    else $error("flying change missed braking point");
  a_ext_early_change: assert property (r_reg.fsm == ST_RUN && r_reg.cont == CONT_EXT && ext_edge
    && !motion_i.brake_point && quiet |=> r_reg.fsm == ST_SEARCH)
    else $error("external edge before braking point ignored");
  a_wait_parks: assert property (r_reg.fsm == ST_RUN && r_reg.cont == CONT_WAIT && !ext_edge
    && motion_i.standstill_in_window && quiet |=> r_reg.fsm == ST_PARK)
    else $error("wait block did not park at target");
  a_missed_alarm: assert property (r_reg.fsm == ST_RUN && r_reg.cont == CONT_ALARM && !ext_edge
    && motion_i.standstill_in_window && quiet |=> missed_external_change_alarm_o)
    else $error("missed external change not flagged");
  a_hold_gated: assert property (!hold_request_n_i |=> hold_o == $past(mode_ok))
    else $error("hold output does not follow mode gate");
  a_cancel_decel: assert property (cancel_req |=> cancel_o && r_reg.fsm == ST_IDLE
    && brake_decel_o == $past(r_reg.max_decel))
    else $error("cancel did not stop with maximum deceleration");
  a_search_bounded: assert property ($rose(r_reg.fsm == ST_SEARCH) |-> ##[1:66] r_reg.fsm != ST_SEARCH)
    else $error("block search did not finish");
  a_status_read: assert property (rd_i && addr_i == REG_STATUS |=> rdata_o[3:0] == $past(r_reg.fsm))
    else $error("status read returned wrong state");

  c_select_start: cover property (act_edge ##1 start_o);
  c_sequence_advance: cover property (r_reg.fsm == ST_SEARCH ##[1:66] start_o);
  c_missed_alarm: cover property ($rose(missed_external_change_alarm_o));
  c_cancel_run: cover property (r_reg.fsm == ST_RUN ##1 cancel_o);
endmodule // tbs_sequencer

`default_nettype wire

// File: inc/tbs_pkg.sv
// constants and carrier types for the traversing block sequencer
// assumes one 250 MHz clock and a plain word-addressed register port
package tbs_pkg;
  // table size and reset values
  localparam int unsigned TBS_ENTRIES = 64;
  localparam logic [6:0] MAX_COUNT_RST = 7'h40;
  localparam logic [7:0] NUM_SKIP = 8'hFF;
  localparam logic [2:0] CONFIG_RST = 3'h1;
  localparam logic [15:0] MAX_DECEL_RST = 16'hFFFF;
  localparam logic [15:0] HOLD_DECEL_RST = 16'h0100;
  localparam logic [3:0] HIDE_ON = 4'h1;
  // register word addresses
  localparam logic [11:0] REG_MAX_COUNT = 12'h000;
  localparam logic [11:0] REG_CONFIG = 12'h001;
  localparam logic [11:0] REG_MAX_DECEL = 12'h002;
  localparam logic [11:0] REG_HOLD_DECEL = 12'h003;
  localparam logic [11:0] REG_STATUS = 12'h004;
  // table window: addr[11]=1, entry in addr[9:4], field in addr[2:0]
  localparam int ADDR_TABLE_BIT = 11;
  localparam int IDX_LSB = 4;
  localparam int IDX_MSB = 9;
  localparam int FLD_MSB = 2;
  localparam logic [2:0] FLD_NUM = 3'h0;
  localparam logic [2:0] FLD_CODE = 3'h1;
  localparam logic [2:0] FLD_TARGET = 3'h2;
  localparam logic [2:0] FLD_VEL = 3'h3;
  localparam logic [2:0] FLD_ACC = 3'h4;
  localparam logic [2:0] FLD_DEC = 3'h5;
  localparam logic [2:0] FLD_MODE = 3'h6;
  localparam logic [2:0] FLD_ARG = 3'h7;
  // config bits
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_FAULT_BIT = 1;
  localparam int CFG_HOLDSRC_BIT = 2;
  // status bits (state one-hot in [3:0])
  localparam int ST_HIDE_BIT = 4;
  localparam int ST_MISS_BIT = 5;
  localparam int ST_FAULT_BIT = 6;
  localparam int ST_MODE_BIT = 7;
  // task-mode nibble positions
  localparam int HIDE_LSB = 0;
  localparam int CONT_LSB = 4;
  localparam int POSM_LSB = 8;

  typedef enum logic [3:0] {
    TASK_POSITIONING = 4'h1, TASK_FIXED_STOP = 4'h2, TASK_ENDLESS_POS = 4'h3,
    TASK_ENDLESS_NEG = 4'h4, TASK_WAIT = 4'h5, TASK_JUMP = 4'h6,
    TASK_SET_OUTPUT = 4'h7, TASK_RESET_OUTPUT = 4'h8, TASK_JERK = 4'h9
  } tbs_task_type;
  typedef enum logic [3:0] {
    CONT_END = 4'h0, CONT_STOP = 4'h1, CONT_FLY = 4'h2,
    CONT_EXT = 4'h3, CONT_WAIT = 4'h4, CONT_ALARM = 4'h5
  } tbs_cont_type;
  typedef enum logic [3:0] {
    POSM_ABSOLUTE = 4'h0, POSM_RELATIVE = 4'h1,
    POSM_MODULO_POSITIVE_APPROACH = 4'h2, POSM_MODULO_NEGATIVE_APPROACH = 4'h3
  } tbs_posm_type;
  typedef enum logic [1:0] {
    OPM_BLOCKS = 2'h0, OPM_DIRECT_SETPOINT = 2'h1, OPM_JOG = 2'h2, OPM_REFERENCING = 2'h3
  } tbs_opmode_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_SEARCH = 4'h4, ST_PARK = 4'h8
  } tbs_state_type;

  // one stored traversing block
  typedef struct packed {
    logic [7:0] num;
    logic [3:0] code;
    logic [31:0] target;
    logic [31:0] vel;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] mode;
    logic [31:0] arg;
  } tbs_entry_type;
  // status from the trajectory generator
  typedef struct packed {
    logic brake_point;
    logic standstill_in_window;
    logic direction_change;
    logic modulo_axis;
    logic [31:0] actual_pos;
  } tbs_motion_type;
  // command handed to the trajectory generator
  typedef struct packed {
    logic [3:0] task_code;
    logic [31:0] target;
    logic [31:0] vel;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [31:0] arg;
    logic dir_pos_only;
    logic dir_neg_only;
  } tbs_cmd_type;
endpackage

// File: tb/tbs_motion_model.sv
// motion stand-in: brake point, then standstill, a set delay after each load
// assumes start_i is the sequencer's one-cycle load pulse
`timescale 1ns/100ps
`default_nettype none
module tbs_motion_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // bench settings and load pulse
  input wire logic [15:0] dly_i,
  input wire logic [31:0] pos_i,
  input wire logic start_i,
  // status to the sequencer
  output tbs_pkg::tbs_motion_type motion_o
);
  import tbs_pkg::*;
  logic [15:0] cnt_reg;
  // cycles since the last load, saturating
  always_ff @(posedge clock_i) begin
    if (rst_i || start_i)
      cnt_reg <= 16'h0000;
    else if (cnt_reg != 16'hffff)
      cnt_reg <= cnt_reg + 16'h0001;
  end
  // linear axis that never reverses; flags drop while a new block loads
  assign motion_o = '{!start_i && cnt_reg >= dly_i, !start_i && cnt_reg >= {dly_i[14:0], 1'b0}, 1'b0, 1'b0, pos_i};
endmodule // tbs_motion_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the traversing block sequencer
// assumes the motion stand-in answers each load after dly cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tbs_pkg::*;
  // stimulus, all given at time zero
  logic clock_i = 1'b0, rst_i = 1'b1, wr_en = 1'b0, rd_en = 1'b0, act = 1'b0, cont = 1'b0;
  logic ext = 1'b0, prb = 1'b0, hold_n = 1'b1, keep_n = 1'b1, start, halarm, malarm, fault, hold, cancel;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, pos = 32'h0000_0100, lfsr_reg = 32'h0000_c86b, rdata;
  logic [31:0] t [0:7];
  logic [5:0] sel = 6'h00;
  logic [15:0] dly = 16'h0008, bdec;
  tbs_opmode_type opm = OPM_BLOCKS;
  tbs_motion_type motion;
  tbs_cmd_type cmd;
  int err_total = 0, total_checks = 0;
  // 4 ns clock
  always #2 clock_i = ~clock_i;
  tbs_sequencer tbs_sequencer_inst (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_en), .rd_i(rd_en),
    .rdata_o(rdata), .block_select_i(sel), .activate_task_i(act), .continue_strobe_i(cont),
    .external_change_i(ext), .probe_change_i(prb), .hold_request_n_i(hold_n), .keep_task_n_i(keep_n),
    .op_mode_i(opm), .motion_i(motion), .cmd_o(cmd), .start_o(start), .hold_o(hold), .cancel_o(cancel),
    .brake_decel_o(bdec), .hidden_alarm_o(halarm), .missed_external_change_alarm_o(malarm), .fault_o(fault)
  );
  tbs_motion_model tbs_motion_model_inst (
    .clock_i(clock_i), .rst_i(rst_i), .dly_i(dly), .pos_i(pos), .start_i(start), .motion_o(motion)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock_i);
    wr_en <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock_i);
    rd_en <= 1'b0;
    @(posedge clock_i);
    chk(rdata, exp);
  endtask
  // one table entry: number, positioning code, target, deceleration, mode word
  task automatic put(input logic [5:0] i, input logic [7:0] n, input logic [15:0] m, input logic [31:0] v);
    reg_wr({2'b10, i, 1'b0, FLD_NUM}, {24'h00_0000, n});
    reg_wr({2'b10, i, 1'b0, FLD_CODE}, {28'h000_0000, TASK_POSITIONING});
    reg_wr({2'b10, i, 1'b0, FLD_TARGET}, v);
    reg_wr({2'b10, i, 1'b0, FLD_DEC}, {16'h0000, v[15:0]});
    reg_wr({2'b10, i, 1'b0, FLD_MODE}, {16'h0000, m});
  endtask
  // activate rises with index i, then the index is scrambled
  task automatic pick(input logic [5:0] i);
    sel <= i;
    act <= 1'b1;
    @(posedge clock_i);
    act <= 1'b0;
    sel <= lfsr_reg[5:0];
    lfsr_reg = lfsr_next(lfsr_reg);
  endtask
  task automatic wait_start(input int n, input logic want, input logic [31:0] v);
    logic got;
    got = 1'b0;
    repeat (n) begin
      #1;
      if (start === 1'b1) begin
        got = 1'b1;
        break;
      end
      @(posedge clock_i);
    end
    chk({31'h0, got}, {31'h0, want});
    if (got) begin
      chk(cmd.target, v);
      @(posedge clock_i);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far past the expected run
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    finish_test;
  end
  // main sequence
  initial begin
    for (int k = 0; k < 8; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      t[k] = lfsr_reg;
    end
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    reg_rd(REG_MAX_COUNT, 32'h0000_0040);
    reg_rd(REG_CONFIG, 32'h0000_0001);
    reg_rd(REG_MAX_DECEL, 32'h0000_ffff);
    reg_rd(REG_HOLD_DECEL, 32'h0000_0100);
    reg_rd(REG_STATUS, 32'h0000_0001);
    reg_rd(12'h005, 32'h0000_0000);
    reg_rd(12'h8d0, 32'h0000_00ff);
    put(6'h00, 8'h0a, 16'h0010, t[0]);
    put(6'h02, 8'h05, 16'h0200, t[1]);
    put(6'h04, 8'h0b, 16'h0020, t[2]);
    put(6'h03, 8'h0c, 16'h0000, t[3]);
    put(6'h06, 8'h1e, 16'h0001, t[4]);
    put(6'h07, 8'h14, 16'h0030, t[5]);
    put(6'h08, 8'h15, 16'h0100, t[6]);
    // stop, flying and end chain in block-number order
    pick(6'h00);
    wait_start(8, 1'b1, t[0]);
    wait_start(120, 1'b1, t[2]);
    wait_start(120, 1'b1, t[3]);
    wait_start(150, 1'b0, 32'h0);
    reg_wr(REG_CONFIG, 32'h0000_0000);
    cont <= 1'b1;
    @(posedge clock_i);
    cont <= 1'b0;
    wait_start(100, 1'b1, t[5]);
    dly <= 16'h012c;
    ext <= 1'b1;
    @(posedge clock_i);
    ext <= 1'b0;
    wait_start(90, 1'b0, 32'h0);
    prb <= 1'b1;
    @(posedge clock_i);
    prb <= 1'b0;
    wait_start(90, 1'b1, pos + t[6]);
    reg_wr(12'h882, 32'h0000_0000);
    chk(cmd.target, pos + t[6]);
    // hold and cancel against operating mode
    opm <= OPM_JOG;
    hold_n <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({31'h0, hold}, 32'h0);
    opm <= OPM_BLOCKS;
    repeat (3) @(posedge clock_i);
    chk({31'h0, hold}, 32'h1);
    chk({16'h0, bdec}, {16'h0, t[6][15:0]});
    hold_n <= 1'b1;
    opm <= OPM_DIRECT_SETPOINT;
    keep_n <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({31'h0, cancel}, 32'h1);
    chk({16'h0, bdec}, 32'h0000_ffff);
    keep_n <= 1'b1;
    opm <= OPM_BLOCKS;
    repeat (2) @(posedge clock_i);
    // refused selections, then one accepted below the count limit
    pick(6'h06);
    wait_start(6, 1'b0, 32'h0);
    chk({31'h0, halarm}, 32'h1);
    reg_wr(REG_MAX_COUNT, 32'h0000_0004);
    pick(6'h04);
    wait_start(6, 1'b0, 32'h0);
    pick(6'h03);
    wait_start(8, 1'b1, t[3]);
    // modulo-only mode on a linear axis is refused
    pick(6'h02);
    wait_start(6, 1'b0, 32'h0);
    // wait code parks at target, then the probe edge advances
    reg_wr({2'b10, 6'h00, 1'b0, FLD_MODE}, 32'h0000_0040);
    dly <= 16'h0008;
    pick(6'h00);
    wait_start(8, 1'b1, t[0]);
    wait_start(40, 1'b0, 32'h0);
    prb <= 1'b1;
    @(posedge clock_i);
    prb <= 1'b0;
    wait_start(90, 1'b1, t[3]);
    // alarm code with no change by standstill, set up as a fault
    reg_wr(REG_CONFIG, 32'h0000_0002);
    put(6'h01, 8'h02, 16'h0050, t[7]);
    pick(6'h01);
    wait_start(8, 1'b1, t[7]);
    repeat (30) @(posedge clock_i);
    chk({30'h0, malarm, fault}, 32'h0000_0003);
    reg_rd(REG_STATUS, 32'h0000_01f1);
    reg_wr(REG_STATUS, 32'h0000_00f0);
    reg_rd(REG_STATUS, 32'h0000_0101);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
